// ===== rtl/id_page_rom.sv
`timescale 1ns/10ps
module id_page_rom #(
   parameter logic [31:0]  MODEL_TEXT  = page_pkg::MODEL_DEF,
   parameter logic [23:0]  REV_TEXT    = page_pkg::REV_DEF,
   parameter logic [63:0]  MFG_TEXT    = page_pkg::MFG_DEF,
   parameter logic [95:0]  CARD_TEXT   = page_pkg::CARD_DEF,
   parameter logic [63:0]  DATE_TEXT   = page_pkg::DATE_DEF,
   parameter logic [159:0] SERIAL_TEXT = page_pkg::SER_DEF
) (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        reset_n,
   // read port
   input  wire logic [page_pkg::ADDR_W-1:0] addr,
   output logic      [7:0]                  q
);
   import page_pkg::*;

   int unsigned a;
   logic [7:0]  b;

   // fixed identification image, all gaps zero
   always_comb begin
      a = 32'(addr);
      b = 8'h00;
      if (a == 32'(B_CODE)) begin
         b = {2'b00, PAGE_ID};
      end else if (a == 32'(B_LEN)) begin
         b = ID_LEN;
      end else if (a >= MODEL_FIRST && a <= MODEL_LAST) begin
         b = text_byte(160'(MODEL_TEXT), MODEL_LAST - a);
      end else if (a >= REV_FIRST && a <= REV_LAST) begin
         b = text_byte(160'(REV_TEXT), REV_LAST - a);
      end else if (a >= MFG_FIRST && a <= MFG_LAST) begin
         b = text_byte(160'(MFG_TEXT), MFG_LAST - a);
      end else if (a >= CARD_FIRST && a <= CARD_LAST) begin
         b = text_byte(160'(CARD_TEXT), CARD_LAST - a);
      end else if (a >= DATE_FIRST && a <= DATE_LAST) begin
         b = text_byte(160'(DATE_TEXT), DATE_LAST - a);
      end else if (a >= SER_FIRST && a <= SER_LAST) begin
         b = text_byte(SERIAL_TEXT, SER_LAST - a);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= 8'h00;
      end else begin
         q <= b;
      end
   end
endmodule

// ===== rtl/page_pkg.sv
// How it works
// - configuration page byte 0 carries code 25h, byte 1 carries length 14h
// - byte 2 bits 2..1 give negotiated bus speed: async, 5, 10, 20 MHz
// - byte 2 bit 3 is 1 for wide bus, 0 for narrow
// - byte 3 upper nibble holds own target id, lower nibble zero
// - byte 8 upper nibble holds operating mode 0, 1 or 3
// - mirroring mode 1..4 coded by byte 9 bit 7 (high) and byte 10 bit 7 (low)
// - byte 9 bits 1..0 flag drives disabled on mirrored write, cleared when normal
// - byte 10 bits 1..0 flag drives disabled on mirrored read, cleared when normal
// - offline status page byte 0 carries code 26h, byte 1 length 7h
// - byte 2 reports outcome: success, busy, failed or aborted
// - byte 3 reports the code of the extended operation
// - 32-bit seconds since last start or finish, MSB first in bytes 4..7
// - elapsed time reads all ones until any operation starts
// - byte 8 progress: 0 nothing running, 255 complete
// - identification page byte 0 carries code 27h, byte 1 length 26h
// - identification page is read only; a parameter-setting copy is ignored
// - 4-byte integrator model text in bytes 2..5
// - 3-byte firmware revision in bytes 7..9, most significant first
// - 8-byte manufacturer model text in bytes 42..49
// - 12-byte controller card serial in bytes 54..65
// - 8-character date month, day, year in bytes 66..73
// - 20-byte integrator serial text in bytes 82..101
// - 4-byte header: remaining count, two zero bytes, block descriptor length 0
package page_pkg;
   localparam int CODE_W = 6;
   localparam int LEN_W  = 8;
   localparam int ADDR_W = 7;

   localparam logic [5:0] PAGE_CFG = 6'h25;
   localparam logic [5:0] PAGE_OFF = 6'h26;
   localparam logic [5:0] PAGE_ID  = 6'h27;
   localparam logic [1:0] CTRL_CURRENT = 2'h0;

   localparam logic [7:0] CFG_LEN = 8'h14;
   localparam logic [7:0] OFF_LEN = 8'h07;
   localparam logic [7:0] ID_LEN  = 8'h26;

   localparam logic [7:0] HDR_BYTES   = 8'h04;
   localparam logic [7:0] BD_LEN      = 8'h00;
   localparam logic [7:0] CFG_BYTES   = 8'h16;
   localparam logic [7:0] OFF_BYTES   = 8'h09;
   localparam logic [7:0] ID_BYTES    = 8'h66;
   localparam logic [7:0] CFG_TOTAL   = HDR_BYTES + CFG_BYTES;
   localparam logic [7:0] OFF_TOTAL   = HDR_BYTES + OFF_BYTES;
   localparam logic [7:0] ID_TOTAL    = HDR_BYTES + ID_BYTES;

   // byte positions inside the pages
   localparam logic [7:0] B_CODE    = 8'h00;
   localparam logic [7:0] B_LEN     = 8'h01;
   localparam logic [7:0] B_BUS     = 8'h02;
   localparam logic [7:0] B_TID     = 8'h03;
   localparam logic [7:0] B_MODE    = 8'h08;
   localparam logic [7:0] B_WDIS    = 8'h09;
   localparam logic [7:0] B_RDIS    = 8'h0A;
   localparam logic [7:0] B_STAT    = 8'h02;
   localparam logic [7:0] B_OPC     = 8'h03;
   localparam logic [7:0] B_TIME0   = 8'h04;
   localparam logic [7:0] B_TIME3   = 8'h07;
   localparam logic [7:0] B_PROG    = 8'h08;
   localparam logic [7:0] H_COUNT   = 8'h00;
   localparam logic [7:0] H_BDLEN   = 8'h03;

   localparam int unsigned MODEL_FIRST  = 2;
   localparam int unsigned MODEL_LAST   = 5;
   localparam int unsigned REV_FIRST    = 7;
   localparam int unsigned REV_LAST     = 9;
   localparam int unsigned MFG_FIRST    = 42;
   localparam int unsigned MFG_LAST     = 49;
   localparam int unsigned CARD_FIRST   = 54;
   localparam int unsigned CARD_LAST    = 65;
   localparam int unsigned DATE_FIRST   = 66;
   localparam int unsigned DATE_LAST    = 73;
   localparam int unsigned SER_FIRST    = 82;
   localparam int unsigned SER_LAST     = 101;

   // identity text defaults, values arbitrary
   localparam logic [31:0]  MODEL_DEF = 32'h4D_44_4C_31;
   localparam logic [23:0]  REV_DEF   = 24'h30_31_30;
   localparam logic [63:0]  MFG_DEF   = 64'h43_54_4C_52_30_30_30_31;
   localparam logic [95:0]  CARD_DEF  = 96'h43_41_52_44_30_30_30_30_30_30_30_31;
   localparam logic [63:0]  DATE_DEF  = 64'h30_31_30_31_32_30_30_30;
   localparam logic [159:0] SER_DEF   = 160'h53_45_52_49_41_4C_30_30_30_30_30_30_30_30_30_30_30_30_30_31;

   localparam logic [1:0] STAT_OK    = 2'h0;
   localparam logic [1:0] STAT_BUSY  = 2'h1;
   localparam logic [7:0] PROG_NONE  = 8'h00;
   localparam logic [7:0] PROG_DONE  = 8'hFF;
   localparam logic [31:0] TIME_NONE = 32'hFFFF_FFFF;

   localparam int unsigned CLK_NS      = 8;
   localparam int unsigned SECOND_NS   = 1000000000;
   localparam int unsigned SECOND_CYCLES_DEF = SECOND_NS / CLK_NS;

   typedef enum logic [1:0] {SEL_CFG, SEL_OFF, SEL_ID} page_sel_t;
   typedef enum logic [1:0] {X_IDLE, X_FETCH, X_LATCH, X_SEND} xfer_t;

   function automatic logic [7:0] text_byte(input logic [159:0] txt, input int unsigned off);
      return txt[off*8 +: 8];
   endfunction
endpackage

// ===== rtl/status_page_responder.sv
`timescale 1ns/10ps
module status_page_responder #(
   parameter int unsigned  SECOND_CYCLES = page_pkg::SECOND_CYCLES_DEF,
   parameter logic [31:0]  MODEL_TEXT    = page_pkg::MODEL_DEF,
   parameter logic [23:0]  REV_TEXT      = page_pkg::REV_DEF,
   parameter logic [63:0]  MFG_TEXT      = page_pkg::MFG_DEF,
   parameter logic [95:0]  CARD_TEXT     = page_pkg::CARD_DEF,
   parameter logic [63:0]  DATE_TEXT     = page_pkg::DATE_DEF,
   parameter logic [159:0] SERIAL_TEXT   = page_pkg::SER_DEF
) (
   // clock and reset
   input  wire logic                        CLK,
   input  wire logic                        RESET_N,
   // sense request
   input  wire logic                        CMD_VALID,
   output logic                             CMD_READY,
   input  wire logic [page_pkg::CODE_W-1:0] CMD_PAGE_CODE,
   input  wire logic [1:0]                  CMD_PAGE_CTRL,
   input  wire logic [page_pkg::LEN_W-1:0]  CMD_ALLOC_LEN,
   output logic                             CMD_REJECT,
   output logic                             CMD_DONE,
   // returned byte stream
   output logic                             DATA_VALID,
   input  wire logic                        DATA_READY,
   output logic      [7:0]                  DATA_BYTE,
   output logic                             DATA_LAST,
   // parameter-setting page offer
   input  wire logic                        SELECT_VALID,
   input  wire logic [page_pkg::CODE_W-1:0] SELECT_PAGE_CODE,
   output logic                             SELECT_IGNORED,
   // configuration state
   input  wire logic [1:0]                  BUS_SPEED,
   input  wire logic                        BUS_WIDE,
   input  wire logic [3:0]                  TARGET_ID,
   input  wire logic [3:0]                  OPER_MODE,
   input  wire logic [1:0]                  MIRROR_MODE,
   input  wire logic [1:0]                  WRITE_ERR,
   input  wire logic [1:0]                  READ_ERR,
   input  wire logic                        STATUS_NORMAL,
   // offline operation events
   input  wire logic                        OP_START,
   input  wire logic [2:0]                  OP_CODE,
   input  wire logic                        OP_DONE,
   input  wire logic [1:0]                  OP_RESULT,
   input  wire logic [7:0]                  OP_PROGRESS
);
   import page_pkg::*;

   localparam int SEC_W = $clog2(SECOND_CYCLES + 1);
   localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SECOND_CYCLES - 1);

   // disable masks
   logic [1:0] write_disable_mask_reg, write_disable_mask_next;
   logic [1:0] read_disable_mask_reg,  read_disable_mask_next;
   logic       mirror_mode_hi;
   logic       mirror_mode_lo;

   // offline operation state
   logic             busy_reg,     busy_next;
   logic             finished_reg, finished_next;
   logic [1:0]       status_reg,   status_next;
   logic [2:0]       opcode_reg,   opcode_next;
   logic [31:0]      elapsed_reg,  elapsed_next;
   logic [SEC_W-1:0] div_reg,      div_next;
   logic [7:0]       progress;

   // transfer state
   xfer_t      xfer_reg,   xfer_next;
   page_sel_t  page_reg,   page_next;
   logic [7:0] idx_reg,    idx_next;
   logic [7:0] len_reg,    len_next;
   logic [7:0] total_reg,  total_next;
   logic [7:0] data_reg,   data_next;
   logic       reject_reg, reject_next;
   logic       done_reg,   done_next;
   logic       ignore_reg, ignore_next;
   logic [ADDR_W-1:0] rom_addr;
   logic [7:0]        rom_q;
   logic [7:0]        pb;
   logic [7:0]        byte_now;

   assign mirror_mode_hi = MIRROR_MODE[1];
   assign mirror_mode_lo = MIRROR_MODE[0];

   // sticky disable flags, a new error wins over the clear
   always_comb begin
      write_disable_mask_next = (write_disable_mask_reg & ~{2{STATUS_NORMAL}}) | WRITE_ERR;
      read_disable_mask_next  = (read_disable_mask_reg & ~{2{STATUS_NORMAL}}) | READ_ERR;
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         write_disable_mask_reg <= 2'b00;
         read_disable_mask_reg  <= 2'b00;
      end else begin
         write_disable_mask_reg <= write_disable_mask_next;
         read_disable_mask_reg  <= read_disable_mask_next;
      end
   end

   // offline status, elapsed seconds and progress
   always_comb begin
      busy_next     = busy_reg;
      finished_next = finished_reg;
      status_next   = status_reg;
      opcode_next   = opcode_reg;
      elapsed_next  = elapsed_reg;
      div_next      = div_reg;
      if (OP_START) begin
         busy_next     = 1'b1;
         finished_next = 1'b0;
         status_next   = STAT_BUSY;
         opcode_next   = OP_CODE;
         elapsed_next  = 32'h0000_0000;
         div_next      = '0;
      end else if (OP_DONE && busy_reg) begin
         busy_next     = 1'b0;
         finished_next = 1'b1;
         status_next   = OP_RESULT;
         elapsed_next  = 32'h0000_0000;
         div_next      = '0;
      end else if (div_reg == SEC_LAST) begin
         div_next = '0;
         if (elapsed_reg != TIME_NONE || busy_reg || finished_reg) begin
            elapsed_next = elapsed_reg + 32'h0000_0001;
         end
      end else begin
         div_next = div_reg + SEC_W'(1);
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         busy_reg     <= 1'b0;
         finished_reg <= 1'b0;
         status_reg   <= STAT_OK;
         opcode_reg   <= 3'h0;
         elapsed_reg  <= TIME_NONE;
         div_reg      <= '0;
      end else begin
         busy_reg     <= busy_next;
         finished_reg <= finished_next;
         status_reg   <= status_next;
         opcode_reg   <= opcode_next;
         elapsed_reg  <= elapsed_next;
         div_reg      <= div_next;
      end
   end

   // progress byte
   always_comb begin
      if (busy_reg) begin
         progress = OP_PROGRESS;
      end else if (finished_reg) begin
         progress = PROG_DONE;
      end else begin
         progress = PROG_NONE;
      end
   end

   // identification image
   assign rom_addr = ADDR_W'(idx_reg - HDR_BYTES);

   id_page_rom #(
      .MODEL_TEXT  (MODEL_TEXT),
      .REV_TEXT    (REV_TEXT),
      .MFG_TEXT    (MFG_TEXT),
      .CARD_TEXT   (CARD_TEXT),
      .DATE_TEXT   (DATE_TEXT),
      .SERIAL_TEXT (SERIAL_TEXT)
   ) u_id_rom (
      .clk     (CLK),
      .reset_n (RESET_N),
      .addr    (rom_addr),
      .q       (rom_q)
   );

   // byte of the image at the current index
   always_comb begin
      pb       = idx_reg - HDR_BYTES;
      byte_now = 8'h00;
      if (idx_reg < HDR_BYTES) begin
         if (idx_reg == H_COUNT) begin
            byte_now = total_reg - 8'h01;
         end else if (idx_reg == H_BDLEN) begin
            byte_now = BD_LEN;
         end
      end else begin
         unique case (page_reg)
            SEL_CFG: begin
               if (pb == B_CODE) begin
                  byte_now = {2'b00, PAGE_CFG};
               end else if (pb == B_LEN) begin
                  byte_now = CFG_LEN;
               end else if (pb == B_BUS) begin
                  byte_now = {4'h0, BUS_WIDE, BUS_SPEED, 1'b0};
               end else if (pb == B_TID) begin
                  byte_now = {TARGET_ID, 4'h0};
               end else if (pb == B_MODE) begin
                  byte_now = {OPER_MODE, 4'h0};
               end else if (pb == B_WDIS) begin
                  byte_now = {mirror_mode_hi, 5'h00, write_disable_mask_reg};
               end else if (pb == B_RDIS) begin
                  byte_now = {mirror_mode_lo, 5'h00, read_disable_mask_reg};
               end
            end
            SEL_OFF: begin
               if (pb == B_CODE) begin
                  byte_now = {2'b00, PAGE_OFF};
               end else if (pb == B_LEN) begin
                  byte_now = OFF_LEN;
               end else if (pb == B_STAT) begin
                  byte_now = {6'h00, status_reg};
               end else if (pb == B_OPC) begin
                  byte_now = {5'h00, opcode_reg};
               end else if (pb >= B_TIME0 && pb <= B_TIME3) begin
                  byte_now = text_byte(160'(elapsed_reg), 32'(B_TIME3 - pb));
               end else if (pb == B_PROG) begin
                  byte_now = progress;
               end
            end
            SEL_ID: begin
               byte_now = rom_q;
            end
            default: begin
               byte_now = 8'h00;
            end
         endcase
      end
   end

   // request acceptance and byte sequencing
   always_comb begin
      xfer_next   = xfer_reg;
      page_next   = page_reg;
      idx_next    = idx_reg;
      len_next    = len_reg;
      total_next  = total_reg;
      data_next   = data_reg;
      reject_next = 1'b0;
      done_next   = 1'b0;
      ignore_next = SELECT_VALID && (SELECT_PAGE_CODE == PAGE_ID);
      unique case (xfer_reg)
         X_IDLE: begin
            if (CMD_VALID) begin
               idx_next = 8'h00;
               if (CMD_PAGE_CTRL != CTRL_CURRENT) begin
                  reject_next = 1'b1;
               end else if (CMD_PAGE_CODE == PAGE_CFG) begin
                  page_next  = SEL_CFG;
                  total_next = CFG_TOTAL;
               end else if (CMD_PAGE_CODE == PAGE_OFF) begin
                  page_next  = SEL_OFF;
                  total_next = OFF_TOTAL;
               end else if (CMD_PAGE_CODE == PAGE_ID) begin
                  page_next  = SEL_ID;
                  total_next = ID_TOTAL;
               end else begin
                  reject_next = 1'b1;
               end
               if (!reject_next) begin
                  len_next = (CMD_ALLOC_LEN < total_next) ? CMD_ALLOC_LEN : total_next;
                  if (len_next == 8'h00) begin
                     done_next = 1'b1;
                  end else begin
                     xfer_next = X_FETCH;
                  end
               end
            end
         end
         X_FETCH: begin
            xfer_next = X_LATCH;
         end
         X_LATCH: begin
            data_next = byte_now;
            xfer_next = X_SEND;
         end
         X_SEND: begin
            if (DATA_READY) begin
               if (idx_reg == len_reg - 8'h01) begin
                  xfer_next = X_IDLE;
                  done_next = 1'b1;
               end else begin
                  idx_next  = idx_reg + 8'h01;
                  xfer_next = X_FETCH;
               end
            end
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         xfer_reg   <= X_IDLE;
         page_reg   <= SEL_CFG;
         idx_reg    <= 8'h00;
         len_reg    <= 8'h00;
         total_reg  <= 8'h00;
         data_reg   <= 8'h00;
         reject_reg <= 1'b0;
         done_reg   <= 1'b0;
         ignore_reg <= 1'b0;
      end else begin
         xfer_reg   <= xfer_next;
         page_reg   <= page_next;
         idx_reg    <= idx_next;
         len_reg    <= len_next;
         total_reg  <= total_next;
         data_reg   <= data_next;
         reject_reg <= reject_next;
         done_reg   <= done_next;
         ignore_reg <= ignore_next;
      end
   end

   assign CMD_READY      = (xfer_reg == X_IDLE);
   assign CMD_REJECT     = reject_reg;
   assign CMD_DONE       = done_reg;
   assign DATA_VALID     = (xfer_reg == X_SEND);
   assign DATA_BYTE      = data_reg;
   assign DATA_LAST      = (xfer_reg == X_SEND) && (idx_reg == len_reg - 8'h01);
   assign SELECT_IGNORED = ignore_reg;
endmodule

// ===== sim/sense_host.sv
`timescale 1ns/10ps
module sense_host (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // control
   input  wire logic       slow,
   input  wire logic       clr,
   // byte stream
   input  wire logic       data_valid,
   input  wire logic [7:0] data_byte,
   output logic            data_ready
);
   logic [7:0] rx [0:127];
   int         n;
   // takes bytes, stalls every other cycle when slow
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         data_ready <= 1'b0;
         n <= 0;
      end else begin
         data_ready <= slow ? ~data_ready : 1'b1;
         if (clr) begin
            n <= 0;
         end else if (data_valid && data_ready) begin
            rx[n] <= data_byte;
            n <= n + 1;
         end
      end
   end
endmodule

// ===== sim/status_page_responder_chk.sv
`timescale 1ns/10ps
module status_page_responder_chk (
   // clock and reset
   input wire logic                        CLK,
   input wire logic                        RESET_N,
   // sense request
   input wire logic                        CMD_VALID,
   input wire logic                        CMD_READY,
   input wire logic [page_pkg::CODE_W-1:0] CMD_PAGE_CODE,
   input wire logic [1:0]                  CMD_PAGE_CTRL,
   input wire logic [page_pkg::LEN_W-1:0]  CMD_ALLOC_LEN,
   input wire logic                        CMD_REJECT,
   input wire logic                        CMD_DONE,
   // byte stream
   input wire logic                        DATA_VALID,
   input wire logic                        DATA_READY,
   input wire logic [7:0]                  DATA_BYTE,
   input wire logic                        DATA_LAST,
   // page offer
   input wire logic                        SELECT_VALID,
   input wire logic [page_pkg::CODE_W-1:0] SELECT_PAGE_CODE,
   input wire logic                        SELECT_IGNORED
);
   import page_pkg::*;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   logic       legal;
   logic [7:0] alloc_reg;
   logic [7:0] cnt_reg;
   assign legal = (CMD_PAGE_CTRL == 2'h0) && (CMD_PAGE_CODE inside {PAGE_CFG, PAGE_OFF, PAGE_ID});
   // bytes taken since the last accepted command
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         alloc_reg <= 8'h00;
         cnt_reg <= 8'h00;
      end else if (CMD_VALID && CMD_READY) begin
         alloc_reg <= CMD_ALLOC_LEN;
         cnt_reg <= 8'h00;
      end else if (DATA_VALID && DATA_READY) begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
   function automatic logic [7:0] hdr(input logic [5:0] c);
      return (c == PAGE_CFG) ? 8'h19 : (c == PAGE_OFF) ? 8'h0C : 8'h69;
   endfunction
   sequence s_take; CMD_VALID && CMD_READY; endsequence
   sequence s_gap; !DATA_VALID [*2] ##1 DATA_VALID; endsequence
   property p_refuse; s_take ##0 !legal |=> CMD_REJECT && !DATA_VALID; endproperty
   property p_first;
      s_take ##0 (legal && CMD_ALLOC_LEN != 8'h00) |=> !CMD_READY ##0 s_gap ##0 DATA_BYTE == hdr($past(CMD_PAGE_CODE, 3));
   endproperty
   property p_gap; DATA_VALID && DATA_READY && !DATA_LAST |=> s_gap; endproperty
   property p_hold; DATA_VALID && !DATA_READY |=> DATA_VALID && $stable(DATA_BYTE) && $stable(DATA_LAST); endproperty
   property p_end; DATA_VALID && DATA_READY && DATA_LAST |=> CMD_DONE && CMD_READY && !DATA_VALID; endproperty
   property p_zero; s_take ##0 (legal && CMD_ALLOC_LEN == 8'h00) |=> CMD_DONE && !DATA_VALID; endproperty
   property p_alloc; DATA_VALID |-> cnt_reg < alloc_reg; endproperty
   property p_sel; SELECT_VALID && SELECT_PAGE_CODE == PAGE_ID |=> SELECT_IGNORED; endproperty
   property p_sel_no; !(SELECT_VALID && SELECT_PAGE_CODE == PAGE_ID) |=> !SELECT_IGNORED; endproperty
   a_refuse: assert property (p_refuse) else $error("bad request not refused");
   a_first: assert property (p_first) else $error("bad first byte");
   a_gap: assert property (p_gap) else $error("byte spacing wrong");
   a_hold: assert property (p_hold) else $error("byte not held");
   a_end: assert property (p_end) else $error("no done after last byte");
   a_zero: assert property (p_zero) else $error("zero length not done");
   a_alloc: assert property (p_alloc) else $error("byte beyond allocation");
   a_sel: assert property (p_sel) else $error("page not ignored");
   a_sel_no: assert property (p_sel_no) else $error("spurious ignore pulse");
endmodule

bind status_page_responder status_page_responder_chk chk (.*);

// ===== sim/status_page_responder_tb.sv
`timescale 1ns/10ps
`define CHK(x, y) begin total_checks++; if ((x) !== (y)) begin mismatches++; $display("CHECK FAILED %0t got %h exp %h", $time, (x), (y)); end end
module status_page_responder_tb;
   import page_pkg::*;
   logic CLK = 1'b0, RESET_N = 1'b0, CMD_VALID = 1'b0, SELECT_VALID = 1'b0, BUS_WIDE = 1'b0, STATUS_NORMAL = 1'b0;
   logic OP_START = 1'b0, OP_DONE = 1'b0, slow = 1'b0, clr = 1'b0, rej;
   logic CMD_READY, CMD_REJECT, CMD_DONE, DATA_VALID, DATA_READY, DATA_LAST, SELECT_IGNORED;
   logic [5:0] CMD_PAGE_CODE = 6'h00, SELECT_PAGE_CODE = 6'h00;
   logic [1:0] CMD_PAGE_CTRL = 2'h0, BUS_SPEED = 2'h0, MIRROR_MODE = 2'h0, OP_RESULT = 2'h0;
   logic [1:0] WRITE_ERR = 2'h0, READ_ERR = 2'h0;
   logic [3:0] TARGET_ID = 4'h0, OPER_MODE = 4'h0;
   logic [7:0] CMD_ALLOC_LEN = 8'h00, OP_PROGRESS = 8'h00, DATA_BYTE;
   logic [2:0] OP_CODE = 3'h0;
   int mismatches = 0, total_checks = 0, cycles = 0;
   always #4 CLK = ~CLK;
   status_page_responder #(.SECOND_CYCLES(10)) dut (.*);
   sense_host host (.clk(CLK), .reset_n(RESET_N), .slow(slow), .clr(clr), .data_valid(DATA_VALID),
      .data_byte(DATA_BYTE), .data_ready(DATA_READY));
   task automatic summarize();
      if (mismatches == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         summarize();
      end
   end
   function automatic logic [7:0] pb(input int i);
      return host.rx[4 + i];
   endfunction
   // one request, waits for done or refusal
   task automatic sense(input logic [5:0] c, input logic [1:0] pc, input logic [7:0] al);
      @(posedge CLK);
      clr <= 1'b1;
      CMD_VALID <= 1'b1;
      CMD_PAGE_CODE <= c;
      CMD_PAGE_CTRL <= pc;
      CMD_ALLOC_LEN <= al;
      @(posedge CLK);
      CMD_VALID <= 1'b0;
      clr <= 1'b0;
      for (int k = 0; k < 3000; k++) begin
         @(negedge CLK);
         if (CMD_DONE === 1'b1 || CMD_REJECT === 1'b1) break;
      end
      `CHK(CMD_DONE ^ CMD_REJECT, 1'b1)
      rej = CMD_REJECT;
   endtask
   task automatic pulse_op(input logic st, input logic [2:0] oc, input logic [1:0] res);
      @(posedge CLK);
      OP_START <= st;
      OP_DONE <= ~st;
      OP_CODE <= oc;
      OP_RESULT <= res;
      @(posedge CLK);
      OP_START <= 1'b0;
      OP_DONE <= 1'b0;
   endtask
   task automatic t_offline();
      logic [1:0] res;
      sense(6'h26, 2'h0, 8'h0D);
      `CHK(host.n, 13)
      `CHK(host.rx[0], 8'h0C)
      `CHK(pb(0), 8'h26)
      `CHK(pb(1), 8'h07)
      `CHK({pb(4), pb(5), pb(6), pb(7)}, 32'hFFFF_FFFF)
      `CHK(pb(8), 8'h00)
      for (int i = 0; i < 3; i++) begin
         res = (i == 0) ? 2'h0 : 2'(i + 1);
         OP_PROGRESS <= 8'(40 * i + 7);
         pulse_op(1'b1, 3'(2 * i + 3), 2'h0);
         repeat (35) @(posedge CLK);
         sense(6'h26, 2'h0, 8'h0D);
         `CHK(pb(2), 8'h01)
         `CHK(pb(3), {5'h0, 3'(2 * i + 3)})
         `CHK({pb(4), pb(5), pb(6)}, 24'h0)
         `CHK(pb(7) >= 8'h06 && pb(7) <= 8'h08, 1'b1)
         `CHK(pb(8), 8'(40 * i + 7))
         pulse_op(1'b0, 3'h0, res);
         sense(6'h26, 2'h0, 8'h0D);
         `CHK(pb(2), {6'h0, res})
         `CHK(pb(8), 8'hFF)
      end
   endtask
   task automatic t_cfg();
      for (int i = 0; i < 4; i++) begin
         @(posedge CLK);
         BUS_SPEED <= 2'(i);
         BUS_WIDE <= i[0];
         TARGET_ID <= 4'(i * 5);
         OPER_MODE <= 4'((i == 2) ? 3 : (i & 1));
         MIRROR_MODE <= 2'(i);
         sense(6'h25, 2'h0, 8'h1A);
         `CHK(host.n, 26)
         `CHK({host.rx[0], host.rx[1], host.rx[2], host.rx[3]}, 32'h1900_0000)
         `CHK({pb(0), pb(1)}, 16'h2514)
         `CHK(pb(2), {4'h0, i[0], i[1:0], 1'b0})
         `CHK(pb(3), {4'(i * 5), 4'h0})
         `CHK(pb(8), {OPER_MODE, 4'h0})
         `CHK(pb(9), {i[1], 7'h0})
         `CHK(pb(10), {i[0], 7'h0})
         `CHK({pb(4), pb(5), pb(6), pb(7), pb(21)}, 40'h0)
      end
   endtask
   task automatic t_masks();
      @(posedge CLK);
      WRITE_ERR <= 2'b01;
      READ_ERR <= 2'b10;
      @(posedge CLK);
      WRITE_ERR <= 2'b00;
      READ_ERR <= 2'b00;
      sense(6'h25, 2'h0, 8'h1A);
      `CHK(pb(9) & 8'h7F, 8'h01)
      `CHK(pb(10) & 8'h7F, 8'h02)
      @(posedge CLK);
      STATUS_NORMAL <= 1'b1;
      @(posedge CLK);
      STATUS_NORMAL <= 1'b0;
      sense(6'h25, 2'h0, 8'h1A);
      `CHK(pb(9) & 8'h7F, 8'h00)
      `CHK(pb(10) & 8'h7F, 8'h00)
   endtask
   task automatic t_trunc();
      sense(6'h26, 2'h0, 8'h05);
      `CHK(host.n, 5)
      sense(6'h27, 2'h0, 8'h00);
      `CHK({rej, 7'(host.n)}, 8'h00)
      sense(6'h25, 2'h1, 8'h1A);
      `CHK({rej, 7'(host.n)}, 8'h80)
      sense(6'h28, 2'h0, 8'h1A);
      `CHK({rej, 7'(host.n)}, 8'h80)
   endtask
   task automatic t_ident();
      @(posedge CLK);
      slow <= 1'b1;
      sense(6'h27, 2'h0, 8'hFF);
      `CHK(host.n, 106)
      `CHK(host.rx[0], 8'h69)
      `CHK({pb(0), pb(1)}, 16'h2726)
      `CHK({pb(2), pb(3), pb(4), pb(5)}, MODEL_DEF)
      `CHK({pb(7), pb(8), pb(9)}, REV_DEF)
      `CHK({pb(42), pb(49)}, {MFG_DEF[63:56], MFG_DEF[7:0]})
      `CHK({pb(54), pb(65)}, {CARD_DEF[95:88], CARD_DEF[7:0]})
      `CHK({pb(66), pb(73)}, {DATE_DEF[63:56], DATE_DEF[7:0]})
      `CHK({pb(82), pb(101)}, {SER_DEF[159:152], SER_DEF[7:0]})
      `CHK({pb(6), pb(30), pb(50), pb(78)}, 32'h0)
      slow <= 1'b0;
   endtask
   task automatic t_select();
      @(posedge CLK);
      SELECT_VALID <= 1'b1;
      SELECT_PAGE_CODE <= 6'h27;
      @(posedge CLK);
      SELECT_PAGE_CODE <= 6'h25;
      @(negedge CLK);
      `CHK(SELECT_IGNORED, 1'b1)
      @(posedge CLK);
      SELECT_VALID <= 1'b0;
      @(negedge CLK);
      `CHK(SELECT_IGNORED, 1'b0)
   endtask
   initial begin
      repeat (16) @(posedge CLK);
      RESET_N <= 1'b1;
      t_offline();
      t_cfg();
      t_masks();
      t_trunc();
      t_ident();
      t_select();
      summarize();
   end
endmodule
